// file: logic/blcr_pkg.sv
// Purpose: Shared constants for the backlight channel configuration registers
// Assumes: 16-bit registers at their printed byte offsets on the host register port
// Notes: Threshold levels are held in units of 100 mV
package blcr_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int CHANNELS = 6;
	localparam int VOLT_W = 7;
	localparam int STATE_W = 5;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CH5_CURRENT = 10'h1cc;
	localparam logic [ADDR_W-1:0] OFS_SUPPLY_SEL = 10'h288;
	localparam logic [ADDR_W-1:0] OFS_SHORT_FAULT_THRESHOLD = 10'h28a;
	localparam logic [ADDR_W-1:0] OFS_STATE_MON = 10'h2a4;

	// Reset values
	localparam logic [DATA_W-1:0] RST_CH5_CURRENT = 16'h0fff;
	localparam logic [DATA_W-1:0] RST_SUPPLY_SEL = 16'h0000;
	localparam logic [DATA_W-1:0] RST_SHORT_FAULT_THRESHOLD = 16'h0882;

	// Field positions
	localparam int CH5_OFF_BIT = 15;
	localparam int CH5_CUR_HI = 11;
	localparam int CH5_CUR_LO = 0;
	localparam int SUPPLY_HI = 15;
	localparam int SUPPLY_LO = 10;
	localparam int LEVEL_HI = 11;
	localparam int LEVEL_LO = 9;
	localparam int STATE_HI = 4;
	localparam int STATE_LO = 0;

	// Live state codes
	localparam logic [STATE_W-1:0] ST_REGULATOR_STARTUP = 5'h01;
	localparam logic [STATE_W-1:0] ST_NVM_LOAD = 5'h02;
	localparam logic [STATE_W-1:0] ST_STANDBY = 5'h03;
	localparam logic [STATE_W-1:0] ST_BOOST_FIRST = 5'h04;
	localparam logic [STATE_W-1:0] ST_BOOST_LAST = 5'h06;
	localparam logic [STATE_W-1:0] ST_ACTIVE = 5'h07;

	// Short threshold per level code, in 100 mV
	function automatic logic [VOLT_W-1:0] level_limit(input logic [2:0] code);
		logic [VOLT_W-1:0] lim;
		lim = 7'h00;
		unique case (code)
			3'h0: lim = 7'h1a;
			3'h1: lim = 7'h1e;
			3'h2: lim = 7'h22;
			3'h3: lim = 7'h26;
			3'h4: lim = 7'h2a;
			3'h5: lim = 7'h30;
			3'h6: lim = 7'h34;
			3'h7: lim = 7'h3c;
		endcase
		return lim;
	endfunction : level_limit

endpackage : blcr_pkg

// file: logic/blcr_short_detect.sv
// Purpose: Per-channel shorted-LED fault comparison
// Assumes: Pin voltages arrive as 100 mV codes from converters on the same clock
// Notes: Fault flags are levels that follow the inputs one cycle later
`timescale 1ns/1ps
`default_nettype none
module blcr_short_detect (
	// Clock and reset
	input wire logic clock,
	input wire logic rstSyncN,
	// Configuration
	input wire logic driverEnable,
	input wire logic [2:0] shortFaultLevel,
	input wire logic [blcr_pkg::CHANNELS-1:0] detectOff,
	input wire logic [blcr_pkg::VOLT_W-1:0] pinVoltage [blcr_pkg::CHANNELS],
	// Result
	output logic [blcr_pkg::CHANNELS-1:0] shortFault
);

	typedef struct packed {
		logic [blcr_pkg::CHANNELS-1:0] fault;
	} blcr_det_state_t;

	blcr_det_state_t state;
	blcr_det_state_t next_state;
	logic [blcr_pkg::VOLT_W-1:0] limit;

	always_comb
	begin
		limit = blcr_pkg::level_limit(shortFaultLevel);
		next_state = state;
		for (int i = 0; i < blcr_pkg::CHANNELS; i++)
		begin
			// Strictly above the limit, only while the driver runs
			next_state.fault[i] = driverEnable && !detectOff[i] && (pinVoltage[i] > limit);
		end
	end

	always_ff @(posedge clock or negedge rstSyncN)
	begin
		if (!rstSyncN)
			state <= '0;
		else
			state <= next_state;
	end

	assign shortFault = state.fault;

	a_fault_gated_enable: assert property (@(posedge clock) disable iff (!rstSyncN)
		!driverEnable |=> shortFault == '0) else $error("fault flagged while driver off");
	a_fault_follows_cmp: assert property (@(posedge clock) disable iff (!rstSyncN)
		(driverEnable && !detectOff[0] && pinVoltage[0] > blcr_pkg::level_limit(shortFaultLevel))
		|=> shortFault[0]) else $error("channel 0 short missed");
	a_ch5_suppress: assert property (@(posedge clock) disable iff (!rstSyncN)
		detectOff[5] |=> !shortFault[5]) else $error("channel 5 fault while suppressed");

endmodule : blcr_short_detect
`default_nettype wire

// file: logic/blcr_config_regs.sv
// Purpose: Channel five current, supply select, short threshold and state monitor registers
// Assumes: Host serial interface decodes frames into single-cycle register strobes
// Notes: Read data appears the cycle after the read strobe and holds until the next read
// Behaviour
// - Channel five bit 15 set disables its short fault detection; resets clear.
// - Channel five bits 11..0 hold its current code, reset all ones.
// - Bits 15..10 pick external supply per channel, five down to zero; reset zero.
// - Short fault when pin voltage exceeds selected level, driver enabled; default code four.
// - Bits 4..0 read live device state code; zero after reset.
`timescale 1ns/1ps
`default_nettype none
module blcr_config_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [blcr_pkg::ADDR_W-1:0] regAddr,
	input wire logic [blcr_pkg::DATA_W-1:0] regWdata,
	output logic [blcr_pkg::DATA_W-1:0] regRdata,
	// Device state and fault inputs
	input wire logic [blcr_pkg::STATE_W-1:0] deviceState,
	input wire logic driverEnable,
	input wire logic [blcr_pkg::CHANNELS-2:0] otherDetectOff,
	input wire logic [blcr_pkg::VOLT_W-1:0] pinVoltage [blcr_pkg::CHANNELS],
	// Configuration outputs
	output logic ch5ShortDetectOff,
	output logic [11:0] ch5CurrentCode,
	output logic [blcr_pkg::CHANNELS-1:0] externalSupplySelect,
	output logic [2:0] shortFaultLevel,
	output logic [blcr_pkg::CHANNELS-1:0] shortFault
);

	typedef struct packed {
		logic [blcr_pkg::DATA_W-1:0] ch5Reg;
		logic [blcr_pkg::DATA_W-1:0] supplyReg;
		logic [blcr_pkg::DATA_W-1:0] threshReg;
		logic [blcr_pkg::STATE_W-1:0] liveState;
		logic [blcr_pkg::DATA_W-1:0] rdata;
	} blcr_reg_state_t;

	blcr_reg_state_t state;
	blcr_reg_state_t next_state;
	logic [1:0] rstPipe;
	logic rstSyncN;

	// Release of reset is synchronised; assertion stays asynchronous
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rstPipe <= 2'h0;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end

	assign rstSyncN = rstPipe[1];

	function automatic logic [blcr_pkg::DATA_W-1:0] read_mux(
		input logic [blcr_pkg::ADDR_W-1:0] addr,
		input blcr_reg_state_t s);
		logic [blcr_pkg::DATA_W-1:0] d;
		d = '0;
		unique case (addr)
			blcr_pkg::OFS_CH5_CURRENT: d = s.ch5Reg;
			blcr_pkg::OFS_SUPPLY_SEL: d = s.supplyReg;
			blcr_pkg::OFS_SHORT_FAULT_THRESHOLD: d = s.threshReg;
			blcr_pkg::OFS_STATE_MON: d[blcr_pkg::STATE_HI:blcr_pkg::STATE_LO] = s.liveState;
			default: d = '0;
		endcase
		return d;
	endfunction : read_mux

	always_comb
	begin
		next_state = state;
		// Sampled every cycle; a read returns the state sampled one cycle before the read strobe
		next_state.liveState = deviceState;
		if (regWrite)
		begin
			// Whole words are kept, reserved writable bits included
			unique case (regAddr)
				blcr_pkg::OFS_CH5_CURRENT: next_state.ch5Reg = regWdata;
				blcr_pkg::OFS_SUPPLY_SEL: next_state.supplyReg = regWdata;
				blcr_pkg::OFS_SHORT_FAULT_THRESHOLD: next_state.threshReg = regWdata;
				default: next_state.ch5Reg = state.ch5Reg;
			endcase
		end
		if (regRead)
			next_state.rdata = read_mux(regAddr, state);
	end

	always_ff @(posedge clock or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			state.ch5Reg <= blcr_pkg::RST_CH5_CURRENT;
			state.supplyReg <= blcr_pkg::RST_SUPPLY_SEL;
			state.threshReg <= blcr_pkg::RST_SHORT_FAULT_THRESHOLD;
			state.liveState <= '0;
			state.rdata <= '0;
		end
		else
			state <= next_state;
	end

	assign regRdata = state.rdata;
	assign ch5ShortDetectOff = state.ch5Reg[blcr_pkg::CH5_OFF_BIT];
	assign ch5CurrentCode = state.ch5Reg[blcr_pkg::CH5_CUR_HI:blcr_pkg::CH5_CUR_LO];
	assign externalSupplySelect = state.supplyReg[blcr_pkg::SUPPLY_HI:blcr_pkg::SUPPLY_LO];
	assign shortFaultLevel = state.threshReg[blcr_pkg::LEVEL_HI:blcr_pkg::LEVEL_LO];

	blcr_short_detect u_detect (
		.clock(clock),
		.rstSyncN(rstSyncN),
		.driverEnable(driverEnable),
		.shortFaultLevel(shortFaultLevel),
		.detectOff({ch5ShortDetectOff, otherDetectOff}),
		.pinVoltage(pinVoltage),
		.shortFault(shortFault)
	);

	a_ch5_write_current: assert property (@(posedge clock) disable iff (!rstSyncN)
		regWrite && regAddr == blcr_pkg::OFS_CH5_CURRENT
		|=> ch5CurrentCode == $past(regWdata[blcr_pkg::CH5_CUR_HI:blcr_pkg::CH5_CUR_LO]))
		else $error("current code not stored");
	a_ch5_write_off: assert property (@(posedge clock) disable iff (!rstSyncN)
		regWrite && regAddr == blcr_pkg::OFS_CH5_CURRENT
		|=> ch5ShortDetectOff == $past(regWdata[blcr_pkg::CH5_OFF_BIT]))
		else $error("detect off not stored");
	a_supply_map: assert property (@(posedge clock) disable iff (!rstSyncN)
		regWrite && regAddr == blcr_pkg::OFS_SUPPLY_SEL
		|=> externalSupplySelect == $past(regWdata[blcr_pkg::SUPPLY_HI:blcr_pkg::SUPPLY_LO]))
		else $error("supply bits wrong");
	a_level_write: assert property (@(posedge clock) disable iff (!rstSyncN)
		regWrite && regAddr == blcr_pkg::OFS_SHORT_FAULT_THRESHOLD
		|=> shortFaultLevel == $past(regWdata[blcr_pkg::LEVEL_HI:blcr_pkg::LEVEL_LO]))
		else $error("level not stored");
	a_monitor_read: assert property (@(posedge clock) disable iff (!rstSyncN)
		regRead && regAddr == blcr_pkg::OFS_STATE_MON
		|=> regRdata == {11'h000, $past(deviceState, 2)}) else $error("monitor read wrong");
	a_reserved_keep: assert property (@(posedge clock) disable iff (!rstSyncN)
		regWrite && regAddr == blcr_pkg::OFS_SHORT_FAULT_THRESHOLD ##1 regRead
		&& regAddr == blcr_pkg::OFS_SHORT_FAULT_THRESHOLD && !regWrite
		|=> regRdata == $past(regWdata, 2)) else $error("reserved bits lost");
	a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstSyncN)
		regRead && regAddr != blcr_pkg::OFS_CH5_CURRENT && regAddr != blcr_pkg::OFS_SUPPLY_SEL
		&& regAddr != blcr_pkg::OFS_SHORT_FAULT_THRESHOLD && regAddr != blcr_pkg::OFS_STATE_MON
		|=> regRdata == '0) else $error("unmapped read not zero");

endmodule : blcr_config_regs
`default_nettype wire

// file: tb/blcr_config_regs_tb_top.sv
// Purpose: Self-checking bench for the channel configuration registers
// Assumes: Strobes change 1 ns after the rising edge
// Notes: Fault limits are kept here in 100 mV, apart from the package function
`timescale 1ns/1ps
`default_nettype none
module blcr_config_regs_tb_top;
	typedef struct packed {logic [9:0] a; logic [15:0] w; logic [15:0] r;} blcr_row_t;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [9:0] regAddr = 10'h000;
	logic [15:0] regWdata = 16'h0000;
	logic [15:0] regRdata;
	logic [4:0] deviceState = 5'h00;
	logic driverEnable = 1'b0;
	logic [4:0] otherDetectOff = 5'h00;
	logic [6:0] pinVoltage [6] = '{default: 7'h00};
	logic ch5ShortDetectOff;
	logic [11:0] ch5CurrentCode;
	logic [5:0] externalSupplySelect;
	logic [2:0] shortFaultLevel;
	logic [5:0] shortFault;
	int n_fail = 0;
	int n_compared = 0;
	logic [15:0] rdv;
	logic [2:0] code;
	logic [6:0] lim [8] = '{7'h1a, 7'h1e, 7'h22, 7'h26, 7'h2a, 7'h30, 7'h34, 7'h3c};
	// Write then read back; the last two rows are refused writes
	blcr_row_t rows [7] = '{
		'{10'h1cc, 16'hf123, 16'hf123}, '{10'h288, 16'hfc00, 16'hfc00},
		'{10'h288, 16'h03ff, 16'h03ff}, '{10'h28a, 16'hffff, 16'hffff},
		'{10'h28a, 16'h0882, 16'h0882}, '{10'h2a4, 16'hffff, 16'h0000},
		'{10'h100, 16'hffff, 16'h0000}};
	always #2 clock = ~clock;
	blcr_config_regs DUT (.clock(clock), .reset_n(reset_n), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.deviceState(deviceState), .driverEnable(driverEnable),
		.otherDetectOff(otherDetectOff), .pinVoltage(pinVoltage),
		.ch5ShortDetectOff(ch5ShortDetectOff), .ch5CurrentCode(ch5CurrentCode),
		.externalSupplySelect(externalSupplySelect), .shortFaultLevel(shortFaultLevel),
		.shortFault(shortFault));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			n_fail++;
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clock) #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
		@(posedge clock) #1 regWrite = 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		@(posedge clock) #1 {regRead, regAddr} = {1'b1, a};
		@(posedge clock) #1 regRead = 1'b0;
		d = regRdata;
	endtask : rd
	// Fault flags lag their inputs by one cycle, so two edges are enough
	task automatic flt(input logic [5:0] exp);
		repeat (2) @(posedge clock);
		#1 chk("shortFault", {10'h000, shortFault}, {10'h000, exp});
	endtask : flt
	task automatic tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (5) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge clock);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rdv);
			chk("readback", rdv, rows[i].r);
		end
		// Back-to-back write then read, then a read that meets a write to the same word
		@(posedge clock) #1 {regWrite, regAddr, regWdata} = {1'b1, 10'h28a, 16'h5a5a};
		@(posedge clock) #1 {regWrite, regRead} = 2'b01;
		@(posedge clock) #1 {regWrite, regRead, regWdata} = {2'b11, 16'h1234};
		chk("b2bRead", regRdata, 16'h5a5a);
		@(posedge clock) #1 {regWrite, regRead} = 2'b00;
		chk("sameCycle", regRdata, 16'h5a5a);
		rd(10'h28a, rdv);
		chk("afterSame", rdv, 16'h1234);
		wr(10'h1cc, 16'h8abc);
		chk("rdHold", regRdata, 16'h1234);
		chk("offBit", {15'h0, ch5ShortDetectOff}, 16'h0001);
		chk("current", {4'h0, ch5CurrentCode}, 16'h0abc);
		wr(10'h288, 16'h8400);
		chk("supply", {10'h0, externalSupplySelect}, 16'h0021);
		// Mid-run reset must bring back every documented reset value
		reset_n = 1'b0;
		repeat (3) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge clock);
		#1 chk("rdRst", regRdata, 16'h0000);
		chk("offRst", {15'h0, ch5ShortDetectOff}, 16'h0000);
		chk("curRst", {4'h0, ch5CurrentCode}, 16'h0fff);
		chk("supRst", {10'h0, externalSupplySelect}, 16'h0000);
		chk("lvlRst", {13'h0, shortFaultLevel}, 16'h0004);
		rd(10'h1cc, rdv);
		chk("rst1cc", rdv, 16'h0fff);
		rd(10'h28a, rdv);
		chk("rst28a", rdv, 16'h0882);
		rd(10'h2a4, rdv);
		chk("rst2a4", rdv, 16'h0000);
		driverEnable = 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			code = c[2:0];
			wr(10'h28a, {4'h0, code, 9'h082});
			chk("level", {13'h0, shortFaultLevel}, {13'h0, code});
			pinVoltage[0] = lim[c];
			flt(6'h00);
			pinVoltage[0] = lim[c] + 7'h01;
			flt(6'h01);
		end
		otherDetectOff = 5'h01;
		flt(6'h00);
		{otherDetectOff, driverEnable, pinVoltage[5]} = {5'h00, 1'b0, 7'h7f};
		flt(6'h00);
		driverEnable = 1'b1;
		flt(6'h21);
		wr(10'h1cc, 16'h8fff);
		flt(6'h01);
		for (int c = 1; c < 8; c++)
		begin
			deviceState = c[4:0];
			rd(10'h2a4, rdv);
			chk("state", rdv, {11'h000, c[4:0]});
		end
		tally_and_finish();
	end
endmodule : blcr_config_regs_tb_top
`default_nettype wire
